// File: hw/debug_port_consts.svh
// Constants of the two-wire debug port
`ifndef DEBUG_PORT_CONSTS_SVH
`define DEBUG_PORT_CONSTS_SVH
`define SEL_IDENTITY     8'h00
`define SEL_REVISION     8'h01
`define SEL_FLASH_CTL    8'h02
`define SEL_FLASH_DATA   8'hB4
`define CMD_BLOCK_READ   8'h06
`define CMD_BLOCK_WRITE  8'h07
`define CMD_PAGE_ERASE   8'h08
`define CMD_DEVICE_ERASE 8'h03
`define INS_DATA_READ    2'h0
`define INS_ADDR_WRITE   2'h2
`define INS_ADDR_READ    2'h1
`define INS_DATA_WRITE   2'h3
`define BYTE_BITS        3'h7
`define ZERO_BYTE        8'h00
`define RESET_SAMPLES    8'hFF
`define INS_LAST_BIT     3'h1
`define DATA_LINE_IDLE   1'b1
`endif

// File: hw/debug_port_pkg.sv
// Types of the two-wire debug port
package debug_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_INS   = 3'b001,
		ST_WDATA = 3'b010,
		ST_TURN  = 3'b011,
		ST_RDATA = 3'b100,
		ST_END   = 3'b101
	} link_state_e;
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} flash_cmd_s;
endpackage

// File: hw/line_sync.sv
// Two-stage synchroniser with edge detection
`timescale 1ns/1ns
module line_sync #(
	parameter logic IDLE_LEVEL = 1'b0 // Level the pin rests at between transfers
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic first;
	logic second;
	logic prev;
	// First stage feeds only the second stage
	// Reset to the idle level so that no false edge follows reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			first  <= IDLE_LEVEL;
			second <= IDLE_LEVEL;
			prev   <= IDLE_LEVEL;
		end else begin
			first  <= async_in;
			second <= first;
			prev   <= second;
		end
	end
	assign level = second;
	assign rise  = second & ~prev;
	assign fall  = ~second & prev;
endmodule

// File: hw/two_wire_flash_debug_port.sv
// Device end of the two-wire flash debug port
// What this block does
// - Host clock line and one shared two-way data line carry all traffic.
// - Host-written 8-bit target select chooses the register for data commands.
// - Select zero makes data reads return device identity.
// - Select one makes data reads return silicon revision.
// - Select two reads and writes the flash program control register.
// - Select B4 reads and writes the flash program data register.
// - Flash data register carries commands, addresses and data bytes.
// - Code 06 written to flash data starts a block read.
// - Code 07 written to flash data starts a block write.
// - Code 08 erases a page, 03 erases the device; others invalid.
// - While halted, reset pin is the clock line and port2 bit0 the data.
`timescale 1ns/1ns
`include "debug_port_consts.svh"
module two_wire_flash_debug_port
	import debug_port_pkg::*;
#(
	parameter logic [7:0] IDENTITY_VALUE = 8'h5A, // Arbitrary value
	parameter logic [7:0] REVISION_VALUE = 8'h01  // Arbitrary value
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       halted,
	input  wire logic       debug_clock_line,
	input  wire logic       debug_data_in,
	output logic            debug_data_out,
	output logic            debug_data_oe,
	output logic            port2_bit0_user_en,
	output logic            reset_pin_user_en,
	output logic      [7:0] flash_program_control,
	output flash_cmd_s      flash_cmd,
	output logic            flash_data_stb,
	output logic      [7:0] flash_data_wr,
	input  wire logic [7:0] flash_data_rd,
	input  wire logic       flash_data_rd_stb
);
	//--------------------------------------------------------------
	// Pin sampling
	//--------------------------------------------------------------
	logic ck_level;
	logic ck_rise;
	logic ck_fall;
	logic d_level;
	logic d_rise;
	logic d_fall;
	line_sync u_ck (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in (debug_clock_line),
		.level    (ck_level),
		.rise     (ck_rise),
		.fall     ()
	);
	// Data pin rests high on its pull-up
	line_sync #(.IDLE_LEVEL(`DATA_LINE_IDLE)) u_d (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in (debug_data_in),
		.level    (d_level),
		.rise     (d_rise),
		.fall     (d_fall)
	);
	//--------------------------------------------------------------
	// Frame state
	//--------------------------------------------------------------
	link_state_e state;
	logic [1:0]  ins;
	logic [2:0]  bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  target_select;
	logic [7:0]  flash_program_data;
	logic [7:0]  rd_value;
	logic        done_byte;
	// frame marker, data toggles while the clock is high
	// Read bits and the release after them move while the clock is high,
	// so the marker is masked then; a read frame cannot be cut short
	wire line_owned = (state == ST_RDATA) || (state == ST_END);
	wire marker = ck_level & (d_rise | d_fall) & ~line_owned;
	assign done_byte = (bitcnt == `BYTE_BITS);
	// Register selected by the target select for reads
	function automatic logic [7:0] read_mux(input logic [7:0] sel,
		input logic [7:0] ctl, input logic [7:0] dat);
		unique case (sel)
			`SEL_IDENTITY:   read_mux = IDENTITY_VALUE;
			`SEL_REVISION:   read_mux = REVISION_VALUE;
			`SEL_FLASH_CTL:  read_mux = ctl;
			`SEL_FLASH_DATA: read_mux = dat;
			default:         read_mux = `ZERO_BYTE;
		endcase
	endfunction
	assign rd_value = read_mux(target_select, flash_program_control, flash_program_data);
	// Bit engine: one bit per rising clock edge
	always_ff @(posedge ref_clk) begin
		if (rst || !halted) begin
			state  <= ST_IDLE;
			ins    <= 2'h0;
			bitcnt <= 3'h0;
			shreg  <= `ZERO_BYTE;
		end else if (marker) begin
			state  <= ST_INS;
			bitcnt <= 3'h0;
		end else if (ck_rise) begin
			unique case (state)
				ST_IDLE: state <= ST_IDLE;
				ST_INS: begin
					ins    <= {ins[0], d_level};
					bitcnt <= bitcnt + 3'h1;
					if (bitcnt == `INS_LAST_BIT) begin
						bitcnt <= 3'h0;
						if ({ins[0], d_level} == `INS_ADDR_WRITE ||
							{ins[0], d_level} == `INS_DATA_WRITE)
							state <= ST_WDATA;
						else begin
							state <= ST_TURN;
							shreg <= ({ins[0], d_level} == `INS_ADDR_READ) ?
								target_select : rd_value;
						end
					end
				end
				ST_WDATA: begin
					shreg  <= {d_level, shreg[7:1]};
					bitcnt <= bitcnt + 3'h1;
					if (done_byte)
						state <= ST_END;
				end
				ST_TURN: state <= ST_RDATA;
				ST_RDATA: begin
					shreg  <= {1'b0, shreg[7:1]};
					bitcnt <= bitcnt + 3'h1;
					if (done_byte)
						state <= ST_END;
				end
				ST_END: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end
	//--------------------------------------------------------------
	// Register writes
	//--------------------------------------------------------------
	wire wr_done = ck_rise && state == ST_WDATA && done_byte && halted && !marker;
	wire [7:0] wr_byte = {d_level, shreg[7:1]};
	// target select written by address write
	always_ff @(posedge ref_clk) begin
		if (rst)
			target_select <= `ZERO_BYTE;
		else if (wr_done && ins == `INS_ADDR_WRITE)
			target_select <= wr_byte;
	end
	always_ff @(posedge ref_clk) begin
		if (rst)
			flash_program_control <= `ZERO_BYTE;
		else if (wr_done && ins == `INS_DATA_WRITE && target_select == `SEL_FLASH_CTL)
			flash_program_control <= wr_byte;
	end
	// data channel, flash side may reload it; host write wins
	always_ff @(posedge ref_clk) begin
		if (rst)
			flash_program_data <= `ZERO_BYTE;
		else if (wr_done && ins == `INS_DATA_WRITE && target_select == `SEL_FLASH_DATA)
			flash_program_data <= wr_byte;
		else if (flash_data_rd_stb)
			flash_program_data <= flash_data_rd;
	end
	// first valid command byte after entering halt is the command, later bytes are operands
	logic cmd_seen;
	always_ff @(posedge ref_clk) begin
		if (rst || !halted) begin
			cmd_seen       <= 1'b0;
			flash_cmd      <= '0;
			flash_data_stb <= 1'b0;
			flash_data_wr  <= `ZERO_BYTE;
		end else begin
			flash_cmd.valid <= 1'b0;
			flash_data_stb  <= 1'b0;
			if (wr_done && ins == `INS_DATA_WRITE && target_select == `SEL_FLASH_DATA) begin
				flash_data_wr <= wr_byte;
				if (!cmd_seen) begin
					// block read block write erases, others dropped
					if (wr_byte == `CMD_BLOCK_READ || wr_byte == `CMD_BLOCK_WRITE ||
						wr_byte == `CMD_PAGE_ERASE || wr_byte == `CMD_DEVICE_ERASE) begin
						flash_cmd.valid <= 1'b1;
						flash_cmd.code  <= wr_byte;
						cmd_seen        <= 1'b1;
					end
				end else
					flash_data_stb <= 1'b1;
			end
		end
	end
	//--------------------------------------------------------------
	// Pin drive
	//--------------------------------------------------------------
	// device drives data only during read bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			debug_data_oe  <= 1'b0;
			debug_data_out <= 1'b0;
		end else begin
			debug_data_oe  <= halted && state == ST_RDATA;
			debug_data_out <= shreg[0];
		end
	end
	assign port2_bit0_user_en = ~halted;
	assign reset_pin_user_en  = ~halted;
	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	a_sel_write: assert property (@(posedge ref_clk) disable iff (rst)
		wr_done && ins == `INS_ADDR_WRITE |=> target_select == $past(wr_byte))
		else $error("target select not updated");
	a_ctl_write: assert property (@(posedge ref_clk) disable iff (rst)
		wr_done && ins == `INS_DATA_WRITE && target_select == `SEL_FLASH_CTL
		|=> flash_program_control == $past(wr_byte))
		else $error("control not written");
	// Identity must reach the shift register when a data read is decoded
	a_id_read: assert property (@(posedge ref_clk) disable iff (rst)
		ck_rise && halted && !marker && state == ST_INS && bitcnt == `INS_LAST_BIT &&
		{ins[0], d_level} == `INS_DATA_READ && target_select == `SEL_IDENTITY
		|=> shreg == IDENTITY_VALUE)
		else $error("identity read wrong");
	a_rev_read: assert property (@(posedge ref_clk) disable iff (rst)
		target_select == `SEL_REVISION |-> rd_value == REVISION_VALUE)
		else $error("revision read wrong");
	a_data_read: assert property (@(posedge ref_clk) disable iff (rst)
		target_select == `SEL_FLASH_DATA |-> rd_value == flash_program_data)
		else $error("data read wrong");
	a_cmd_valid: assert property (@(posedge ref_clk) disable iff (rst)
		flash_cmd.valid |-> flash_cmd.code inside {`CMD_BLOCK_READ, `CMD_BLOCK_WRITE,
		`CMD_PAGE_ERASE, `CMD_DEVICE_ERASE})
		else $error("invalid command issued");
	a_cmd_once: assert property (@(posedge ref_clk) disable iff (rst)
		flash_cmd.valid |=> !flash_cmd.valid)
		else $error("command held too long");
	a_oe_halt: assert property (@(posedge ref_clk) disable iff (rst)
		debug_data_oe |-> $past(halted) && $past(state) == ST_RDATA)
		else $error("data driven outside read");
	c_read: cover property (@(posedge ref_clk) state == ST_RDATA);
	c_cmd: cover property (@(posedge ref_clk) flash_cmd.valid);
	c_dat: cover property (@(posedge ref_clk) flash_data_stb);
endmodule

// File: tb/debug_host_model.sv
// Host adapter model that drives the two-wire debug link
`timescale 1ns/1ns
module debug_host_model (
	output logic      clk_line,
	output logic      drv,
	output logic      drv_oe,
	input  wire logic line
);
	// Clock idles low between frames; data released to the pull-up
	initial begin
		clk_line = 1'b0;
		drv = 1'b1;
		drv_oe = 1'b0;
	end
	// One 125 ns clock; data moves mid low phase, away from both clock edges
	task automatic pulse(input logic b, input logic own);
		#31 drv = b;
		drv_oe = own;
		#32 clk_line = 1'b1;
		#62 clk_line = 1'b0;
	endtask
	task automatic xfer(input logic [1:0] ins, input logic [7:0] wd,
		output logic [7:0] rd);
		rd = 8'h00;
		drv = 1'b1;
		drv_oe = 1'b1;
		#63 clk_line = 1'b1;
		#30 drv = 1'b0; // Marker: data moves while the clock is high
		#32 clk_line = 1'b0;
		pulse(ins[1], 1'b1);
		pulse(ins[0], 1'b1);
		if (ins[1]) begin
			for (int i = 0; i < 8; i++) pulse(wd[i], 1'b1);
		end else begin
			pulse(1'b1, 1'b0); // Turnaround hands the line over
			for (int i = 0; i < 8; i++) begin
				#62 rd[i] = line; // Sample late in the low phase
				#1 clk_line = 1'b1;
				#62 clk_line = 1'b0;
			end
		end
		pulse(1'b1, 1'b0);
	endtask
endmodule

// File: tb/two_wire_flash_debug_port_tb_top.sv
// Self-checking bench for the two-wire flash debug port
`timescale 1ns/1ns
`include "debug_port_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %h want %h", $time, a, e); end end
module two_wire_flash_debug_port_tb_top;
	import debug_port_pkg::*;
	localparam logic [7:0] ID = 8'h3C; // Arbitrary value
	localparam logic [7:0] REV = 8'hC7; // Arbitrary value
	logic       ref_clk, rst, halted, hclk, hdrv, hoe, line, d_out, d_oe;
	logic       p2_en, rst_en, stb, rd_stb;
	logic [7:0] ctl, wr, rd_val, got, last_cmd, last_op;
	logic [7:0] codes [4] = '{`CMD_BLOCK_READ, `CMD_BLOCK_WRITE, `CMD_PAGE_ERASE,
		`CMD_DEVICE_ERASE};
	flash_cmd_s cmd;
	int         bad_count, n_tests, n_cmd, n_op;
	// Shared data line with a pull-up when nobody drives it
	assign line = d_oe ? d_out : (hoe ? hdrv : 1'b1);
	two_wire_flash_debug_port #(.IDENTITY_VALUE(ID), .REVISION_VALUE(REV))
		two_wire_flash_debug_port_i (.ref_clk(ref_clk), .rst(rst), .halted(halted),
		.debug_clock_line(hclk), .debug_data_in(line), .debug_data_out(d_out),
		.debug_data_oe(d_oe), .port2_bit0_user_en(p2_en), .reset_pin_user_en(rst_en),
		.flash_program_control(ctl), .flash_cmd(cmd), .flash_data_stb(stb),
		.flash_data_wr(wr), .flash_data_rd(rd_val), .flash_data_rd_stb(rd_stb));
	debug_host_model debug_host_model_i (.clk_line(hclk), .drv(hdrv), .drv_oe(hoe),
		.line(line));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Count command and operand pulses as they appear
	always @(posedge ref_clk) begin
		if (cmd.valid === 1'b1) begin
			n_cmd++;
			last_cmd = cmd.code;
		end
		if (stb === 1'b1) begin
			n_op++;
			last_op = wr;
		end
	end
	task automatic give_verdict;
		$display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Frames start just after a clock edge so link edges never meet ref_clk edges
	task automatic xf(input logic [1:0] ins, input logic [7:0] d);
		@(posedge ref_clk);
		#1 debug_host_model_i.xfer(ins, d, got);
	endtask
	task automatic acc(input logic [7:0] a, input logic [1:0] ins, input logic [7:0] d);
		xf(`INS_ADDR_WRITE, a);
		xf(ins, d);
	endtask
	task automatic set_halt(input logic h);
		@(posedge ref_clk);
		#1 halted = h;
		repeat (4) @(posedge ref_clk);
	endtask
	initial begin
		#600000;
		bad_count++;
		give_verdict;
	end
	initial begin
		halted = 1'b0;
		rst = 1'b1;
		rd_val = 8'h00;
		rd_stb = 1'b0;
		repeat (20) @(posedge ref_clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		`CHK(ctl, 8'h00)
		`CHK({p2_en, rst_en}, 2'b11)
		acc(`SEL_FLASH_CTL, `INS_DATA_WRITE, 8'hA5);
		`CHK(ctl, 8'h00)
		set_halt(1'b1);
		`CHK({p2_en, rst_en}, 2'b00)
		acc(`SEL_IDENTITY, `INS_DATA_READ, 8'h00);
		`CHK(got, ID)
		acc(`SEL_REVISION, `INS_DATA_READ, 8'h00);
		`CHK(got, REV)
		xf(`INS_ADDR_READ, 8'h00);
		`CHK(got, `SEL_REVISION)
		acc(`SEL_FLASH_CTL, `INS_DATA_WRITE, 8'h96);
		`CHK(ctl, 8'h96)
		xf(`INS_DATA_READ, 8'h00);
		`CHK(got, 8'h96)
		foreach (codes[i]) begin
			set_halt(1'b0);
			set_halt(1'b1);
			n_cmd = 0;
			n_op = 0;
			acc(`SEL_FLASH_DATA, `INS_DATA_WRITE, 8'h55);
			`CHK(n_cmd, 0)
			xf(`INS_DATA_WRITE, codes[i]);
			`CHK(last_cmd, codes[i])
			xf(`INS_DATA_WRITE, 8'hE1);
			`CHK({n_cmd, n_op}, {32'd1, 32'd1})
			`CHK(last_op, 8'hE1)
		end
		xf(`INS_DATA_READ, 8'h00);
		`CHK(got, 8'hE1)
		@(posedge ref_clk);
		#1 rd_val = 8'h9E;
		rd_stb = 1'b1;
		@(posedge ref_clk);
		#1 rd_stb = 1'b0;
		xf(`INS_DATA_READ, 8'h00);
		`CHK(got, 8'h9E)
		give_verdict;
	end
endmodule
